// >>> design/cgp_map.svh
// Register offsets, reset values and field sizes of the GPIO port block.
// Assumes byte addresses on an 8-bit register port with 32-bit data.
`ifndef CGP_MAP_SVH
`define CGP_MAP_SVH

`define CGP_PORTS         3
`define CGP_PINS          24
`define CGP_PORT_STRIDE   8'h20
`define CGP_NO_PORT       2'd3
`define CGP_T2_A_CH1      5'd0
`define CGP_T2_A_CH2      5'd3
`define CGP_T2_A_CH3      5'd1
`define CGP_T2_A_CH4      5'd2
`define CGP_T2_B_CH1      5'd9
`define CGP_T2_B_CH2      5'd10
`define CGP_T2_B_CH3      5'd11
`define CGP_T2_B_CH4      5'd12
`define CGP_OFF_CFG_LO    8'h00
`define CGP_OFF_CFG_HI    8'h04
`define CGP_OFF_LEVEL     8'h08
`define CGP_OFF_OUT       8'h0c
`define CGP_OFF_SET       8'h10
`define CGP_OFF_CLR       8'h14
`define CGP_OFF_WAKE      8'h18
`define CGP_OFF_T2_OPT    8'h60
`define CGP_OFF_T2_EN     8'h64
`define CGP_OFF_IRQ_STAT  8'h68
`define CGP_OFF_IRQ_MASK  8'h6c
`define CGP_CFG_RESET     16'h4444
`define CGP_T2_OPT_LSB    4
`define CGP_T2_OPT_BITS   4

`endif

// >>> design/cgp_pkg.sv
// Types shared by the GPIO port block: pin modes.
// Assumes the map header carries all numeric offsets.
package cgp_pkg;

	typedef enum logic [3:0] {
		CGP_ANALOG    = 4'b0000,
		CGP_IN_FLOAT  = 4'b0100,
		CGP_IN_PULL   = 4'b1000,
		CGP_OUT_PP    = 4'b0001,
		CGP_OUT_OD    = 4'b0101,
		CGP_ALT_PP    = 4'b1001,
		CGP_ALT_OD    = 4'b1101
	} cgp_mode_e;

	typedef logic [3:0] cgp_nib_t;

endpackage

// >>> design/cgp_pad_ctl.sv
// Per-pin pad control: decodes a 4-bit mode into drive and pull controls.
// Assumes the caller registers every output before it reaches a pad.
`timescale 1ns/1ps
`default_nettype none
module cgp_pad_ctl (
	input  wire logic           mode_i,
	input  wire cgp_pkg::cgp_nib_t mode_val_i,
	input  wire logic           out_bit_i,
	input  wire logic           alt_bit_i,
	output logic                drive_o,
	output logic                oe_o,
	output logic                pull_up_o,
	output logic                pull_down_o,
	output logic                analog_o
);
	import cgp_pkg::*;

	always_comb begin
		drive_o     = 1'b0;
		oe_o        = 1'b0;
		pull_up_o   = 1'b0;
		pull_down_o = 1'b0;
		analog_o    = 1'b0;
		case (mode_val_i)
			CGP_ANALOG: begin
				analog_o = mode_i;
			end
			CGP_IN_FLOAT: begin
				oe_o = 1'b0;
			end
			CGP_IN_PULL: begin
				pull_up_o   = out_bit_i;
				pull_down_o = ~out_bit_i;
			end
			CGP_OUT_PP: begin
				drive_o = out_bit_i;
				oe_o    = 1'b1;
			end
			CGP_OUT_OD: begin
				// Open drain only ever pulls low
				oe_o = ~out_bit_i;
			end
			CGP_ALT_PP: begin
				drive_o = alt_bit_i;
				oe_o    = 1'b1;
			end
			CGP_ALT_OD: begin
				oe_o = ~alt_bit_i;
			end
			default: begin
				oe_o = 1'b0;
			end
		endcase
	end

endmodule // cgp_pad_ctl
`default_nettype wire

// >>> design/cgp_ports.sv
// Three eight-pin GPIO ports with mode control, wake and timer 2 steering.
// Assumes software on a simple strobe port and peripherals on one clock.
`timescale 1ns/1ps
`default_nettype none
`include "cgp_map.svh"
module cgp_ports (
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [31:0] reg_rdata_o,
	input  wire logic [23:0] pin_i,
	output logic      [23:0] pin_o,
	output logic      [23:0] pin_oe_o,
	output logic      [23:0] pull_up_o,
	output logic      [23:0] pull_down_o,
	output logic      [23:0] analog_en_o,
	output logic      [23:0] alt_in_o,
	input  wire logic [23:0] serial_alt_out_i,
	input  wire logic [23:0] serial_alt_present_i,
	input  wire logic        timer2_channel1_out_i,
	input  wire logic        timer2_channel2_out_i,
	input  wire logic        timer2_channel3_out_i,
	input  wire logic        timer2_channel4_out_i,
	output logic             wake_o,
	output logic             irq_o
);
	import cgp_pkg::*;

	typedef struct packed {
		logic [2:0][15:0] cfg_lo;
		logic [2:0][15:0] cfg_hi;
		logic [2:0][7:0]  out_lvl;
		logic [2:0][7:0]  wake_sel;
		logic [3:0]       t2_opt;
		logic [3:0]       t2_en;
		logic [23:0]      irq_stat;
		logic [23:0]      irq_mask;
		logic [23:0]      sync1;
		logic [23:0]      sync2;
		logic [23:0]      level;
		logic [31:0]      rdata;
		logic [23:0]      drv;
		logic [23:0]      oe;
		logic [23:0]      pu;
		logic [23:0]      pd;
		logic [23:0]      ana;
		logic             wake;
	} cgp_state_s;

	cgp_state_s st_reg;
	cgp_state_s st_next;

	logic [23:0] out_flat;
	logic [23:0] alt_val;
	logic [23:0] t2_hit;
	logic [23:0] t2_val;
	logic [3:0]  t2_ch;
	logic [23:0] pad_drv;
	logic [23:0] pad_oe;
	logic [23:0] pad_pu;
	logic [23:0] pad_pd;
	logic [23:0] pad_ana;
	logic [23:0] wake_flat;

	// Port index of an address, or 3 when it is outside the port window
	function automatic logic [1:0] port_of(input logic [7:0] a);
		logic [1:0] p;
		p = `CGP_NO_PORT;
		if (a < `CGP_PORT_STRIDE) begin
			p = 2'd0;
		end else if (a < 8'(2 * `CGP_PORT_STRIDE)) begin
			p = 2'd1;
		end else if (a < 8'(3 * `CGP_PORT_STRIDE)) begin
			p = 2'd2;
		end
		return p;
	endfunction

	// Offset of an address inside its port window
	function automatic logic [7:0] off_of(input logic [7:0] a);
		return a & 8'(`CGP_PORT_STRIDE - 8'h01);
	endfunction

	// Read word of a per-port register; write-only offsets read zero
	function automatic logic [31:0] port_rd(input cgp_state_s s,
	                                        input logic [1:0]  p,
	                                        input logic [7:0]  o);
		logic [31:0] w;
		w = 32'h00000000;
		if (o == `CGP_OFF_CFG_LO) begin
			w = {16'h0000, s.cfg_lo[p]};
		end else if (o == `CGP_OFF_CFG_HI) begin
			w = {16'h0000, s.cfg_hi[p]};
		end else if (o == `CGP_OFF_LEVEL) begin
			w = {24'h000000, s.level[p*8 +: 8]};
		end else if (o == `CGP_OFF_OUT) begin
			w = {24'h000000, s.out_lvl[p]};
		end else if (o == `CGP_OFF_WAKE) begin
			w = {24'h000000, s.wake_sel[p]};
		end
		return w;
	endfunction

	// Read word of a block-wide register; unmapped addresses read zero
	function automatic logic [31:0] glob_rd(input cgp_state_s s,
	                                        input logic [7:0]  a);
		logic [31:0] w;
		w = 32'h00000000;
		if (a == `CGP_OFF_T2_OPT) begin
			w = {24'h000000, s.t2_opt, 4'h0};
		end else if (a == `CGP_OFF_T2_EN) begin
			w = {28'h0000000, s.t2_en};
		end else if (a == `CGP_OFF_IRQ_STAT) begin
			w = {8'h00, s.irq_stat};
		end else if (a == `CGP_OFF_IRQ_MASK) begin
			w = {8'h00, s.irq_mask};
		end
		return w;
	endfunction

	// Pin index steered from timer 2 channel c by option bit sel
	function automatic logic [4:0] t2_pin(input logic [1:0] c,
	                                      input logic sel);
		logic [4:0] p;
		p = `CGP_T2_A_CH1;
		if (sel && c == 2'd0) begin
			p = `CGP_T2_B_CH1;
		end else if (sel && c == 2'd1) begin
			p = `CGP_T2_B_CH2;
		end else if (sel && c == 2'd2) begin
			p = `CGP_T2_B_CH3;
		end else if (sel) begin
			p = `CGP_T2_B_CH4;
		end else if (c == 2'd0) begin
			p = `CGP_T2_A_CH1;
		end else if (c == 2'd1) begin
			p = `CGP_T2_A_CH2;
		end else if (c == 2'd2) begin
			p = `CGP_T2_A_CH3;
		end else begin
			p = `CGP_T2_A_CH4;
		end
		return p;
	endfunction

	// Mode nibble of pin b from its port's low and high mode words
	function automatic cgp_nib_t mode_of(input logic [15:0] lo_w,
	                                     input logic [15:0] hi_w,
	                                     input logic [2:0]  b);
		cgp_nib_t n;
		if (b[2]) begin
			n = hi_w[b[1:0]*4 +: 4];
		end else begin
			n = lo_w[b[1:0]*4 +: 4];
		end
		return n;
	endfunction

	// New output byte after a write to OUT, SET or CLR
	function automatic logic [7:0] out_upd(input logic [7:0] cur,
	                                       input logic [7:0] off,
	                                       input logic [7:0] d);
		logic [7:0] r;
		r = cur;
		if (off == `CGP_OFF_OUT) begin
			r = d;
		end else if (off == `CGP_OFF_SET) begin
			r = cur | d;
		end else if (off == `CGP_OFF_CLR) begin
			r = cur & ~d;
		end
		return r;
	endfunction

	assign out_flat = {st_reg.out_lvl[2], st_reg.out_lvl[1],
	                   st_reg.out_lvl[0]};
	assign t2_ch = {timer2_channel4_out_i, timer2_channel3_out_i,
	                timer2_channel2_out_i, timer2_channel1_out_i};
	assign wake_flat = {st_reg.wake_sel[2], st_reg.wake_sel[1],
	                    st_reg.wake_sel[0]};

	// Timer 2 claims its routed pins only while its channel is enabled
	// Channels land on distinct pins, so no two claims collide
	always_comb begin
		t2_hit = 24'h000000;
		t2_val = 24'h000000;
		for (int c = 0; c < 4; c++) begin
			if (st_reg.t2_en[c]) begin
				t2_hit[t2_pin(2'(c), st_reg.t2_opt[c])] = 1'b1;
				t2_val[t2_pin(2'(c), st_reg.t2_opt[c])] = t2_ch[c];
			end
		end
	end

	// Priority: timer 2, then serial controller, else zero
	always_comb begin
		for (int i = 0; i < `CGP_PINS; i++) begin
			if (t2_hit[i]) begin
				alt_val[i] = t2_val[i];
			end else if (serial_alt_present_i[i]) begin
				alt_val[i] = serial_alt_out_i[i];
			end else begin
				alt_val[i] = 1'b0;
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < `CGP_PINS; g++) begin : g_pad
			localparam int PRT = g / 8;
			localparam int BIT = g % 8;
			cgp_nib_t mode_val;
			assign mode_val = mode_of(st_reg.cfg_lo[PRT], st_reg.cfg_hi[PRT],
			                          3'(BIT));
			cgp_pad_ctl u_pad (
				.mode_i      (1'b1),
				.mode_val_i  (mode_val),
				.out_bit_i   (out_flat[g]),
				.alt_bit_i   (alt_val[g]),
				.drive_o     (pad_drv[g]),
				.oe_o        (pad_oe[g]),
				.pull_up_o   (pad_pu[g]),
				.pull_down_o (pad_pd[g]),
				.analog_o    (pad_ana[g])
			);
		end
	endgenerate

	always_comb begin
		logic [1:0]  p;
		logic [7:0]  o;
		logic [23:0] chg;
		st_next = st_reg;
		p   = port_of(reg_addr_i);
		o   = off_of(reg_addr_i);
		chg = 24'h000000;

		// Pin inputs cross in through two flops
		st_next.sync1 = pin_i;
		st_next.sync2 = st_reg.sync1;
		// Analog pins see a high input everywhere downstream
		st_next.level = st_reg.sync2 | st_reg.ana;

		// Level changes on wake-selected pins
		// Only selected pins, so idle pins cannot wake the core
		chg = (st_reg.level ^ st_next.level) & wake_flat;
		st_next.wake = |chg;

		// Pad controls registered so pins never glitch
		st_next.drv = pad_drv;
		st_next.oe  = pad_oe & ~pad_ana;
		st_next.pu  = pad_pu;
		st_next.pd  = pad_pd;
		st_next.ana = pad_ana;

		st_next.rdata = 32'h00000000;
		if (reg_wr_i) begin
			if (p != `CGP_NO_PORT) begin
				if (o == `CGP_OFF_CFG_LO) begin
					st_next.cfg_lo[p] = reg_wdata_i[15:0];
				end else if (o == `CGP_OFF_CFG_HI) begin
					st_next.cfg_hi[p] = reg_wdata_i[15:0];
				end else if (o == `CGP_OFF_OUT || o == `CGP_OFF_SET ||
				             o == `CGP_OFF_CLR) begin
					// One update per write keeps set and clear atomic
					st_next.out_lvl[p] = out_upd(st_reg.out_lvl[p], o,
					                             reg_wdata_i[7:0]);
				end else if (o == `CGP_OFF_WAKE) begin
					st_next.wake_sel[p] = reg_wdata_i[7:0];
				end
			end else if (reg_addr_i == `CGP_OFF_T2_OPT) begin
				st_next.t2_opt = reg_wdata_i[`CGP_T2_OPT_LSB +:
				                             `CGP_T2_OPT_BITS];
			end else if (reg_addr_i == `CGP_OFF_T2_EN) begin
				st_next.t2_en = reg_wdata_i[3:0];
			end else if (reg_addr_i == `CGP_OFF_IRQ_STAT) begin
				st_next.irq_stat = st_reg.irq_stat & ~reg_wdata_i[23:0];
			end else if (reg_addr_i == `CGP_OFF_IRQ_MASK) begin
				st_next.irq_mask = reg_wdata_i[23:0];
			end
		end
		// A fresh change outranks a clear in the same cycle
		st_next.irq_stat = st_next.irq_stat | chg;

		// Read data stand one cycle only, zero otherwise
		if (reg_rd_i) begin
			if (p != `CGP_NO_PORT) begin
				st_next.rdata = port_rd(st_reg, p, o);
			end else begin
				st_next.rdata = glob_rd(st_reg, reg_addr_i);
			end
		end
	end

	// Mode fields leave reset as inputs so no pin fights the board
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			st_reg          <= '0;
			for (int k = 0; k < `CGP_PORTS; k++) begin
				st_reg.cfg_lo[k] <= `CGP_CFG_RESET;
				st_reg.cfg_hi[k] <= `CGP_CFG_RESET;
			end
		end else begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata_o = st_reg.rdata;
	// Open drain drive value is always low
	assign pin_o       = st_reg.drv;
	assign pin_oe_o    = st_reg.oe;
	assign pull_up_o   = st_reg.pu;
	assign pull_down_o = st_reg.pd;
	assign analog_en_o = st_reg.ana;
	assign alt_in_o    = st_reg.level;
	assign wake_o      = st_reg.wake;
	// Level, not pulse, so a late handler still sees the request
	assign irq_o       = |(st_reg.irq_stat & st_reg.irq_mask);

endmodule // cgp_ports
`default_nettype wire

// >>> bench/cgp_ports_assertions.sv
// Concurrent checks on the GPIO block's pad and bus outputs.
// Assumes it is bound to cgp_ports and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module cgp_ports_assertions (
	input wire logic        core_clk_i,
	input wire logic        rst_i,
	input wire logic        reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic [23:0] pin_i,
	input wire logic [23:0] pin_o,
	input wire logic [23:0] pin_oe_o,
	input wire logic [23:0] pull_up_o,
	input wire logic [23:0] pull_down_o,
	input wire logic [23:0] analog_en_o,
	input wire logic        wake_o
);
	logic [23:0] pin_prev_reg;
	logic [7:0]  chg_reg;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	// Pin history; a wake pulse needs a recent cause
	always_ff @(posedge core_clk_i) begin
		pin_prev_reg <= pin_i;
		chg_reg <= rst_i ? 8'h00 : {chg_reg[6:0], pin_i != pin_prev_reg};
	end
	chk_reset_modes: assert property ($fell(rst_i) |->
		(pin_oe_o | pull_up_o | pull_down_o | analog_en_o) == 24'h0)
		else $error("pads busy after reset");
	chk_pull_clash: assert property (
		(pull_up_o & pull_down_o) == 24'h0) else $error("both pulls on");
	chk_analog_drive: assert property (
		(analog_en_o & pin_oe_o) == 24'h0) else $error("analog pin driven");
	chk_analog_pull: assert property (
		(analog_en_o & (pull_up_o | pull_down_o)) == 24'h0)
		else $error("analog pin pulled");
	chk_drive_pull: assert property (
		(pin_oe_o & (pull_up_o | pull_down_o)) == 24'h0)
		else $error("driven pin pulled");
	chk_drive_gate: assert property (
		(pin_o & ~pin_oe_o) == 24'h0) else $error("value without enable");
	chk_wake_cause: assert property (
		wake_o |-> chg_reg != 8'h00) else $error("wake without pin change");
	chk_read_idle: assert property (
		!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
		else $error("read data outside slot");
endmodule // cgp_ports_assertions
`default_nettype wire

// >>> bench/cgp_periph_model.sv
// Stand-in for the peripherals behind the alternate pin functions.
// Assumes the bench changes its values just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module cgp_periph_model (
	input  wire logic        core_clk_i,
	input  wire logic [23:0] ser_val_i,
	input  wire logic [23:0] ser_pres_i,
	input  wire logic [3:0]  chan_i,
	output logic      [23:0] serial_alt_out_o,
	output logic      [23:0] serial_alt_present_o,
	output logic      [3:0]  chan_o
);
	logic flip_reg = 1'b0;
	// Unattached lines toggle, so a stale value never looks right
	always_ff @(posedge core_clk_i) begin
		flip_reg <= ~flip_reg;
		serial_alt_out_o <= (ser_val_i & ser_pres_i) |
			(~ser_pres_i & {24{flip_reg}});
		serial_alt_present_o <= ser_pres_i;
		chan_o <= chan_i;
	end
endmodule // cgp_periph_model
`default_nettype wire

// >>> bench/test_configurable_gpio_ports.sv
// Self-checking bench for the three-port GPIO block.
// Assumes the map header, the peripheral model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "cgp_map.svh"
module test_configurable_gpio_ports;
	logic        core_clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        reg_wr_i = 1'b0;
	logic        reg_rd_i = 1'b0;
	logic [7:0]  reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0;
	logic [31:0] reg_rdata_o, seed = 32'd13917, lo [3], hi [3], ov [3];
	logic [23:0] pin_i = 24'h0, sv = 24'h0, sp = 24'h0;
	logic [23:0] pin_o, pin_oe_o, pull_up_o, pull_down_o, analog_en_o;
	logic [23:0] alt_in_o, ser_out, ser_pres, lv;
	logic [3:0]  chv = 4'h0, chan, m;
	logic        wake_o, irq_o;
	logic [3:0]  modes [10] = '{0, 4, 8, 1, 5, 9, 13, 2, 7, 15};
	int          bad_count = 0;
	int          samples_checked = 0;
	always #10 core_clk_i = ~core_clk_i;
	cgp_periph_model cgp_periph_model_inst (.core_clk_i(core_clk_i),
		.ser_val_i(sv), .ser_pres_i(sp), .chan_i(chv),
		.serial_alt_out_o(ser_out), .serial_alt_present_o(ser_pres),
		.chan_o(chan));
	cgp_ports cgp_ports_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
		.pull_up_o(pull_up_o), .pull_down_o(pull_down_o),
		.analog_en_o(analog_en_o), .alt_in_o(alt_in_o),
		.serial_alt_out_i(ser_out), .serial_alt_present_i(ser_pres),
		.timer2_channel1_out_i(chan[0]), .timer2_channel2_out_i(chan[1]),
		.timer2_channel3_out_i(chan[2]), .timer2_channel4_out_i(chan[3]),
		.wake_o(wake_o), .irq_o(irq_o));
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Alternate modes see no peripheral here, so their value is zero
	function automatic logic [4:0] pad_exp(input logic [3:0] m, input logic o);
		logic pp, od, v;
		pp = m == 4'h1 || m == 4'h9;
		od = m == 4'h5 || m == 4'hd;
		v = o && !m[3];
		return {pp | (od & ~v), pp & v, (m == 4'h8) & o, (m == 4'h8) & ~o,
			m == 4'h0};
	endfunction
	function automatic logic [23:0] alt_exp(input logic [23:0] v, s,
		input logic [3:0] c, en, opt);
		int pa [4] = '{0, 3, 1, 2};
		int pb [4] = '{9, 10, 11, 12};
		alt_exp = v & s;
		for (int j = 0; j < 4; j++)
			if (en[j]) alt_exp[opt[j] ? pb[j] : pa[j]] = c[j];
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		#1 chk(reg_rdata_o, exp);
	endtask
	task automatic settle;
		repeat (4) @(posedge core_clk_i);
		#1;
	endtask
	task automatic cfg_all(input logic [31:0] c);
		for (int p = 0; p < 3; p++) begin
			wr(8'(p * 32) + `CGP_OFF_CFG_LO, c);
			wr(8'(p * 32) + `CGP_OFF_CFG_HI, c);
		end
	endtask
	task automatic flip_watch(input logic [23:0] t, input logic exp);
		logic seen;
		seen = 1'b0;
		@(posedge core_clk_i) pin_i <= pin_i ^ t;
		repeat (10) begin
			@(posedge core_clk_i);
			#1 seen = seen | wake_o;
		end
		chk({31'h0, seen}, {31'h0, exp});
	endtask
	task automatic wrap_up;
		if (bad_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge core_clk_i);
		rst_i <= 1'b0;
		for (int p = 0; p < 3; p++) begin
			rd(8'(p * 32) + `CGP_OFF_CFG_LO, 32'h4444);
			rd(8'(p * 32) + `CGP_OFF_CFG_HI, 32'h4444);
		end
		rd(8'h7c, 32'h0);
		// Whole mode table first, then random nibbles per pin
		for (int k = 0; k < 16; k++) begin
			for (int p = 0; p < 3; p++) begin
				seed = nxt(seed);
				lo[p] = k < 10 ? {8{modes[k]}} : seed;
				seed = nxt(seed);
				hi[p] = k < 10 ? {8{modes[k]}} : seed;
				ov[p] = nxt(seed);
				wr(8'(p * 32) + `CGP_OFF_CFG_LO, lo[p]);
				wr(8'(p * 32) + `CGP_OFF_CFG_HI, hi[p]);
				wr(8'(p * 32) + `CGP_OFF_OUT, ov[p]);
			end
			settle;
			for (int i = 0; i < 24; i++) begin
				m = i % 8 < 4 ? lo[i / 8][4 * (i % 4) +: 4] :
					hi[i / 8][4 * (i % 4) +: 4];
				chk({27'h0, pin_oe_o[i], pin_o[i], pull_up_o[i], pull_down_o[i],
					analog_en_o[i]}, {27'h0, pad_exp(m, ov[i / 8][i % 8])});
			end
		end
		for (int p = 0; p < 3; p++) begin
			seed = nxt(seed);
			wr(8'(p * 32) + `CGP_OFF_OUT, seed);
			wr(8'(p * 32) + `CGP_OFF_SET, {seed[15:0], seed[31:16]});
			wr(8'(p * 32) + `CGP_OFF_CLR, seed ^ 32'h5a);
			rd(8'(p * 32) + `CGP_OFF_OUT, {24'h0, (seed[7:0] | seed[23:16]) &
				~(seed[7:0] ^ 8'h5a)});
			rd(8'(p * 32) + `CGP_OFF_SET, 32'h0);
		end
		cfg_all(32'h4444);
		wr(`CGP_OFF_CFG_LO, 32'h0);
		seed = nxt(seed);
		@(posedge core_clk_i) pin_i <= seed[23:0];
		settle;
		lv = {seed[23:4], 4'hf};
		chk({8'h0, alt_in_o}, {8'h0, lv});
		for (int p = 0; p < 3; p++)
			rd(8'(p * 32) + `CGP_OFF_LEVEL, {24'h0, lv[8 * p +: 8]});
		cfg_all(32'h9999);
		for (int k = 0; k < 8; k++) begin
			seed = nxt(seed);
			wr(`CGP_OFF_T2_OPT, {24'h0, seed[27:24], 4'h0});
			wr(`CGP_OFF_T2_EN, {28'h0, seed[31:28]});
			sv <= seed[23:0];
			chv <= seed[3:0] ^ seed[7:4];
			sp <= {seed[11:0], seed[23:12]};
			settle;
			chk({8'h0, pin_o}, {8'h0, alt_exp(sv, sp, chv, seed[31:28],
				seed[27:24])});
			chk({8'h0, pin_oe_o}, 32'hffffff);
		end
		cfg_all(32'h4444);
		wr(`CGP_OFF_WAKE, 32'h1);
		wr(`CGP_OFF_IRQ_MASK, 32'h1);
		flip_watch(24'h1, 1'b1);
		chk({31'h0, irq_o}, 32'h1);
		rd(`CGP_OFF_IRQ_STAT, 32'h1);
		wr(`CGP_OFF_IRQ_STAT, 32'h1);
		settle;
		chk({31'h0, irq_o}, 32'h0);
		flip_watch(24'h2, 1'b0);
		rd(`CGP_OFF_IRQ_STAT, 32'h0);
		wr(`CGP_OFF_IRQ_MASK, 32'h0);
		flip_watch(24'h1, 1'b1);
		chk({31'h0, irq_o}, 32'h0);
		rd(`CGP_OFF_IRQ_STAT, 32'h1);
		wrap_up;
	end
endmodule // test_configurable_gpio_ports
bind cgp_ports cgp_ports_assertions cgp_ports_assertions_inst (
	.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .pin_i(pin_i), .pin_o(pin_o),
	.pin_oe_o(pin_oe_o), .pull_up_o(pull_up_o), .pull_down_o(pull_down_o),
	.analog_en_o(analog_en_o), .wake_o(wake_o));
`default_nettype wire
